// File: core/sfc_defs.vh
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

// ----------------------------------------
// operating modes (one-hot)
// ----------------------------------------
`define SFC_MODE_REAL 4'h1
`define SFC_MODE_V86 4'h2
`define SFC_MODE_PROT 4'h4
`define SFC_MODE_LONG 4'h8

// ----------------------------------------
// instruction classes
// ----------------------------------------
`define SFC_INS_MASKED 3'h1
`define SFC_INS_REGMOVE 3'h2
`define SFC_INS_NONTEMP 3'h4

// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define SFC_EMUL_BIT 2
`define SFC_MOD_REG 2'h3
`define SFC_LOCK_PREFIX 8'hf0
`define SFC_REAL_LIMIT 17'h0ffff
`define SFC_ERR_ZERO 16'h0000
`define SFC_CPL_USER 2'h3
`define SFC_DF_VECTOR 8'h08
`define SFC_VEC_SHIFT 3

// ----------------------------------------
// fault codes
// ----------------------------------------
`define SFC_FC_NONE 4'h0
`define SFC_FC_UD 4'h1
`define SFC_FC_MF 4'h2
`define SFC_FC_SS 4'h3
`define SFC_FC_GP 4'h4
`define SFC_FC_AC 4'h5
`define SFC_FC_DF 4'h6

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SFC_ADDR_STATUS 12'h000
`define SFC_ADDR_CLEAR 12'h004
`define SFC_ADDR_ENABLE 12'h008
`define SFC_ADDR_TLIMIT 12'h00c
`define SFC_ADDR_CTRL 12'h010
`define SFC_ADDR_LAST 12'h014

// ----------------------------------------
// reset values and status bits
// ----------------------------------------
`define SFC_RST_ENABLE 8'h00
`define SFC_RST_TLIMIT 16'h03ff
`define SFC_RST_CTRL 4'h0
`define SFC_ST_UD 0
`define SFC_ST_MF 1
`define SFC_ST_SS 2
`define SFC_ST_GP 3
`define SFC_ST_AC 4
`define SFC_ST_DF 5
`define SFC_ST_SHUT 6
`define SFC_ST_NMI 7
`define SFC_NUM_EV 8

`endif

// File: core/sfc_fault_unit.v
`timescale 1ns/1ps
`include "sfc_defs.vh"

module sfc_fault_unit (
    // clock, reset, enable
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire CLK_EN,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // instruction check request
    input wire CHK_VALID,
    input wire [2:0] CHK_CLASS,
    input wire CHK_MEMREF,
    input wire [3:0] CHK_MODE,
    input wire [1:0] CHK_MODFIELD,
    input wire [7:0] CHK_PREFIX,
    input wire CHK_FEATURE_OK,
    input wire CHK_FPU_PENDING,
    input wire CHK_SS_ILLEGAL,
    input wire CHK_SS_NONCANON,
    input wire CHK_SEG_ILLEGAL,
    input wire CHK_NONCANON,
    input wire CHK_DST_RO,
    input wire CHK_NULL_SEL,
    input wire [16:0] CHK_LAST_BYTE,
    input wire CHK_AC_ENABLE,
    input wire CHK_UNALIGNED,
    input wire [1:0] CHK_CPL,
    // check answer
    output reg FAULT_VALID,
    output reg [3:0] FAULT_CODE,
    output reg [15:0] FAULT_ERRCODE,
    // interrupt delivery request
    input wire DLV_VALID,
    input wire [7:0] DLV_VECTOR,
    input wire DLV_IS_NMI,
    input wire INTERRUPT_RETURN_DONE,
    output reg DLV_DONE,
    output reg DLV_TAKEN,
    output reg [7:0] DLV_OUT_VECTOR,
    output reg DLV_DF,
    output reg SHUTDOWN,
    output reg NMI_BLOCKED,
    // interrupt
    output wire IRQ
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] status;
    reg [7:0] enable;
    reg [15:0] tlimit;
    reg [3:0] ctrl;
    reg [7:0] ev;
    reg [3:0] next_code;
    reg [15:0] next_err;
    reg next_ud;

    wire emul_flag = ctrl[`SFC_EMUL_BIT];
    wire wr_acc = PSEL & PENABLE & PWRITE;
    wire addr_ok = (PADDR < `SFC_ADDR_LAST) && (PADDR[1:0] == 2'h0);

    // register bus decode
    wire rd_setup = PSEL & ~PENABLE & ~PWRITE; // read data latched in setup
    wire clr_acc = wr_acc && (PADDR == `SFC_ADDR_CLEAR); // write-one-to-clear strobe

    // apb answers in the access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~addr_ok;
    assign IRQ = |(status & enable);

    // ----------------------------------------
    // check logic
    // ----------------------------------------
    wire is_masked = CHK_CLASS == `SFC_INS_MASKED;
    wire is_regmove = CHK_CLASS == `SFC_INS_REGMOVE;
    wire mode_real = CHK_MODE == `SFC_MODE_REAL;
    wire mode_v86 = CHK_MODE == `SFC_MODE_V86;
    wire mode_prot = CHK_MODE == `SFC_MODE_PROT;
    wire mode_long = CHK_MODE == `SFC_MODE_LONG;

    // ----------------------------------------
    // per-rule fault conditions
    // ----------------------------------------
    // undefined opcode causes, checked in every mode
    wire ud_emul = emul_flag;
    // masked store must use a register operand format
    wire ud_modfield = is_masked && (CHK_MODFIELD != `SFC_MOD_REG);
    // bus-lock prefix is never legal here
    wire ud_lock = CHK_PREFIX == `SFC_LOCK_PREFIX;
    // instruction not offered by this core
    wire ud_feature = !CHK_FEATURE_OK;

    // pending floating-point error, every mode
    wire mf_pending = CHK_FPU_PENDING;

    // stack faults, memory operand forms only
    wire ss_prot = CHK_MEMREF && mode_prot && CHK_SS_ILLEGAL;
    wire ss_long = CHK_MEMREF && mode_long && CHK_SS_NONCANON;

    // protection faults, memory operand forms only
    wire gp_seg = CHK_MEMREF && mode_prot && CHK_SEG_ILLEGAL;
    // write target in a read-only segment
    wire gp_ro = CHK_MEMREF && mode_prot && (is_masked || is_regmove) && CHK_DST_RO;
    // null data or extra selector, masked store only
    wire gp_null = CHK_MEMREF && is_masked && CHK_NULL_SEL;
    // non-canonical address in 64-bit mode
    wire gp_canon = CHK_MEMREF && mode_long && CHK_NONCANON;
    // operand runs past the 64k window
    wire gp_real = CHK_MEMREF && (mode_real || mode_v86)
                   && (CHK_LAST_BYTE > `SFC_REAL_LIMIT);

    // alignment fault, user level only, never in real mode
    wire ac_user = CHK_MEMREF && !mode_real && CHK_AC_ENABLE && CHK_UNALIGNED
                   && (CHK_CPL == `SFC_CPL_USER);

    // priority: opcode, fpu, stack, protection, alignment
    always @* begin
        next_code = `SFC_FC_NONE;
        next_err = `SFC_ERR_ZERO;
        next_ud = ud_emul;
        if (ud_modfield) begin
            next_ud = 1'b1;
        end
        if (ud_lock) begin
            next_ud = 1'b1;
        end
        if (ud_feature) begin
            next_ud = 1'b1;
        end
        if (next_ud) begin
            next_code = `SFC_FC_UD;
        end else if (mf_pending) begin
            next_code = `SFC_FC_MF;
        end else if (ss_prot) begin
            next_code = `SFC_FC_SS;
        end else if (ss_long) begin
            next_code = `SFC_FC_SS;
        end else if (gp_seg) begin
            next_code = `SFC_FC_GP;
        end else if (gp_ro) begin
            next_code = `SFC_FC_GP;
        end else if (gp_null) begin
            next_code = `SFC_FC_GP;
        end else if (gp_canon) begin
            next_code = `SFC_FC_GP;
        end else if (gp_real) begin
            next_code = `SFC_FC_GP;
        end else if (ac_user) begin
            next_code = `SFC_FC_AC;
        end
    end

    // registered check answer
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            FAULT_VALID <= 1'b0;
            FAULT_CODE <= `SFC_FC_NONE;
            FAULT_ERRCODE <= `SFC_ERR_ZERO;
        end else if (CLK_EN) begin
            FAULT_VALID <= CHK_VALID;
            if (CHK_VALID) begin
                FAULT_CODE <= next_code;
                FAULT_ERRCODE <= next_err;
            end
        end
    end

    // ----------------------------------------
    // interrupt delivery
    // ----------------------------------------
    wire [18:0] ent_end = {8'h00, DLV_VECTOR, 3'h7};
    wire [18:0] df_end = {8'h00, `SFC_DF_VECTOR, 3'h7};
    wire vec_over = ent_end > {3'h0, tlimit};
    wire df_over = df_end > {3'h0, tlimit};
    wire nmi_drop = DLV_IS_NMI & NMI_BLOCKED;
    wire dlv_go = DLV_VALID & ~SHUTDOWN & ~nmi_drop;

    // vector limit check, double fault, shutdown, nmi masking
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            DLV_DONE <= 1'b0;
            DLV_TAKEN <= 1'b0;
            DLV_OUT_VECTOR <= 8'h00;
            DLV_DF <= 1'b0;
            SHUTDOWN <= 1'b0;
            NMI_BLOCKED <= 1'b0;
        end else if (CLK_EN) begin
            DLV_DONE <= DLV_VALID;
            DLV_TAKEN <= dlv_go;
            DLV_DF <= 1'b0;
            if (dlv_go) begin
                DLV_OUT_VECTOR <= DLV_VECTOR;
                if (vec_over) begin
                    if (df_over || DLV_VECTOR == `SFC_DF_VECTOR) begin
                        SHUTDOWN <= 1'b1;
                        DLV_TAKEN <= 1'b0;
                    end else begin
                        DLV_DF <= 1'b1;
                        DLV_OUT_VECTOR <= `SFC_DF_VECTOR;
                    end
                end
            end
            if (dlv_go && DLV_IS_NMI) begin
                NMI_BLOCKED <= 1'b1;
            end else if (INTERRUPT_RETURN_DONE) begin
                NMI_BLOCKED <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // event collection
    // ----------------------------------------
    always @* begin
        ev = 8'h00;
        if (CHK_VALID) begin
            ev[`SFC_ST_UD] = next_code == `SFC_FC_UD;
            ev[`SFC_ST_MF] = next_code == `SFC_FC_MF;
            ev[`SFC_ST_SS] = next_code == `SFC_FC_SS;
            ev[`SFC_ST_GP] = next_code == `SFC_FC_GP;
            ev[`SFC_ST_AC] = next_code == `SFC_FC_AC;
        end
        ev[`SFC_ST_DF] = dlv_go & vec_over & ~df_over & (DLV_VECTOR != `SFC_DF_VECTOR);
        ev[`SFC_ST_SHUT] = dlv_go & vec_over & (df_over | (DLV_VECTOR == `SFC_DF_VECTOR));
        ev[`SFC_ST_NMI] = DLV_VALID & nmi_drop;
    end

    // sticky status, set wins over clear
    genvar i;
    generate
        for (i = 0; i < `SFC_NUM_EV; i = i + 1) begin : g_st
            always @(posedge SYS_CLK) begin
                if (SYS_RST) begin
                    status[i] <= 1'b0;
                end else if (CLK_EN) begin
                    if (ev[i]) begin
                        status[i] <= 1'b1;
                    end else if (clr_acc && PWDATA[i]) begin
                        status[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // register writes and reads
    // ----------------------------------------
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            enable <= `SFC_RST_ENABLE;
            tlimit <= `SFC_RST_TLIMIT;
            ctrl <= `SFC_RST_CTRL;
        end else if (CLK_EN && wr_acc) begin
            case (PADDR)
                `SFC_ADDR_ENABLE: enable <= PWDATA[7:0];
                `SFC_ADDR_TLIMIT: tlimit <= PWDATA[15:0];
                `SFC_ADDR_CTRL: ctrl <= PWDATA[3:0];
                default: ;
            endcase
        end
    end

    // read data, registered during setup
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h00000000;
        end else if (CLK_EN && rd_setup) begin
            case (PADDR)
                `SFC_ADDR_STATUS: PRDATA <= {24'h000000, status};
                `SFC_ADDR_ENABLE: PRDATA <= {24'h000000, enable};
                `SFC_ADDR_TLIMIT: PRDATA <= {16'h0000, tlimit};
                `SFC_ADDR_CTRL: PRDATA <= {28'h0000000, ctrl};
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

endmodule

// File: sim/sfc_fault_unit_chk.sv
`timescale 1ns/1ps
`include "sfc_defs.vh"
// ----
// port checker
// ----
module sfc_fault_unit_chk (
    // clock and reset
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire CLK_EN,
    // check side
    input wire CHK_VALID,
    input wire [3:0] CHK_MODE,
    input wire [7:0] CHK_PREFIX,
    input wire CHK_FEATURE_OK,
    input wire CHK_FPU_PENDING,
    input wire [1:0] CHK_CPL,
    input wire FAULT_VALID,
    input wire [3:0] FAULT_CODE,
    input wire [15:0] FAULT_ERRCODE,
    // delivery side
    input wire DLV_VALID,
    input wire DLV_IS_NMI,
    input wire INTERRUPT_RETURN_DONE,
    input wire DLV_DONE,
    input wire DLV_TAKEN,
    input wire [7:0] DLV_OUT_VECTOR,
    input wire DLV_DF,
    input wire SHUTDOWN,
    input wire NMI_BLOCKED
);
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // accepted check request, nmi arriving while blocked
    sequence s_req;
        CHK_VALID && CLK_EN;
    endsequence
    sequence s_nmi_blocked;
        DLV_VALID && CLK_EN && DLV_IS_NMI && NMI_BLOCKED && !INTERRUPT_RETURN_DONE;
    endsequence
    // undefined opcode answer one cycle after the request
    property p_undef(cond);
        s_req ##0 cond |=> FAULT_VALID && FAULT_CODE == `SFC_FC_UD;
    endproperty
    a_lock_undef: assert property (p_undef(CHK_PREFIX == `SFC_LOCK_PREFIX))
        else $error("lock prefix not refused");
    a_feature_undef: assert property (p_undef(!CHK_FEATURE_OK))
        else $error("missing feature not refused");
    a_fpu_cause: assert property (FAULT_VALID && FAULT_CODE == `SFC_FC_MF |-> $past(CHK_FPU_PENDING))
        else $error("fpu fault without pending error");
    a_error_zero: assert property (FAULT_VALID |-> FAULT_ERRCODE == `SFC_ERR_ZERO)
        else $error("nonzero error code");
    a_align_cause: assert property (FAULT_VALID && FAULT_CODE == `SFC_FC_AC |->
        $past(CHK_MODE) != `SFC_MODE_REAL && $past(CHK_CPL) == `SFC_CPL_USER)
        else $error("alignment fault without cause");
    a_nmi_drop: assert property (s_nmi_blocked |=> DLV_DONE && !DLV_TAKEN && NMI_BLOCKED)
        else $error("blocked nmi delivered");
    a_df_vector: assert property (DLV_DF |-> DLV_DONE && DLV_OUT_VECTOR == `SFC_DF_VECTOR)
        else $error("double fault on wrong vector");
    a_shut_entry: assert property ($rose(SHUTDOWN) |-> DLV_DONE && !DLV_TAKEN ##1 SHUTDOWN[*3])
        else $error("shutdown entry wrong");
endmodule
bind sfc_fault_unit sfc_fault_unit_chk sfc_fault_unit_chk_inst (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .CHK_VALID(CHK_VALID),
    .CHK_MODE(CHK_MODE), .CHK_PREFIX(CHK_PREFIX), .CHK_FEATURE_OK(CHK_FEATURE_OK),
    .CHK_FPU_PENDING(CHK_FPU_PENDING), .CHK_CPL(CHK_CPL), .FAULT_VALID(FAULT_VALID),
    .FAULT_CODE(FAULT_CODE), .FAULT_ERRCODE(FAULT_ERRCODE), .DLV_VALID(DLV_VALID),
    .DLV_IS_NMI(DLV_IS_NMI), .INTERRUPT_RETURN_DONE(INTERRUPT_RETURN_DONE), .DLV_DONE(DLV_DONE),
    .DLV_TAKEN(DLV_TAKEN), .DLV_OUT_VECTOR(DLV_OUT_VECTOR), .DLV_DF(DLV_DF),
    .SHUTDOWN(SHUTDOWN), .NMI_BLOCKED(NMI_BLOCKED)
);

// File: sim/test_sfc_fault_unit.sv
`timescale 1ns/1ps
`include "sfc_defs.vh"
module test_sfc_fault_unit;
    // ----
    // stimulus and results
    // ----
    logic SYS_CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, q;
    logic e, CHK_VALID = 0, DLV_VALID = 0, DLV_IS_NMI = 0, INTERRUPT_RETURN_DONE = 0;
    logic CLK_EN = 1, CHK_MEMREF = 1;
    logic [2:0] CHK_CLASS = 0;
    logic [3:0] CHK_MODE = 0;
    logic [1:0] CHK_MODFIELD = 0, CHK_CPL = 0;
    logic [7:0] CHK_PREFIX = 0, DLV_VECTOR = 0;
    logic [9:0] flg = 0;
    logic [16:0] CHK_LAST_BYTE = 0;
    wire [31:0] PRDATA;
    wire [3:0] FAULT_CODE;
    wire [7:0] DLV_OUT_VECTOR;
    wire PREADY, PSLVERR, FAULT_VALID, DLV_DONE, DLV_TAKEN, DLV_DF, SHUTDOWN, NMI_BLOCKED, IRQ;
    int failures = 0, tests_run = 0, cycles = 0;
    localparam [2:0] M = `SFC_INS_MASKED, R = `SFC_INS_REGMOVE, N = `SFC_INS_NONTEMP;
    localparam [3:0] PM = `SFC_MODE_PROT, LM = `SFC_MODE_LONG, RM = `SFC_MODE_REAL;
    localparam [3:0] OK = `SFC_FC_NONE, BAD = `SFC_FC_UD, FPE = `SFC_FC_MF;
    localparam [3:0] STK = `SFC_FC_SS, PRO = `SFC_FC_GP, ALN = `SFC_FC_AC;
    sfc_fault_unit sfc_fault_unit_inst (
        .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .CHK_VALID(CHK_VALID), .CHK_CLASS(CHK_CLASS), .CHK_MEMREF(CHK_MEMREF),
        .CHK_MODE(CHK_MODE), .CHK_MODFIELD(CHK_MODFIELD), .CHK_PREFIX(CHK_PREFIX),
        .CHK_FEATURE_OK(flg[9]), .CHK_FPU_PENDING(flg[8]), .CHK_SS_ILLEGAL(flg[7]),
        .CHK_SS_NONCANON(flg[6]), .CHK_SEG_ILLEGAL(flg[5]), .CHK_NONCANON(flg[4]),
        .CHK_DST_RO(flg[3]), .CHK_NULL_SEL(flg[2]), .CHK_LAST_BYTE(CHK_LAST_BYTE),
        .CHK_AC_ENABLE(flg[1]), .CHK_UNALIGNED(flg[0]), .CHK_CPL(CHK_CPL),
        .FAULT_VALID(FAULT_VALID), .FAULT_CODE(FAULT_CODE), .FAULT_ERRCODE(),
        .DLV_VALID(DLV_VALID), .DLV_VECTOR(DLV_VECTOR), .DLV_IS_NMI(DLV_IS_NMI),
        .INTERRUPT_RETURN_DONE(INTERRUPT_RETURN_DONE), .DLV_DONE(DLV_DONE), .DLV_TAKEN(DLV_TAKEN),
        .DLV_OUT_VECTOR(DLV_OUT_VECTOR), .DLV_DF(DLV_DF), .SHUTDOWN(SHUTDOWN),
        .NMI_BLOCKED(NMI_BLOCKED), .IRQ(IRQ)
    );
    // ----
    // tasks
    // ----
    task cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask
    // one apb transfer, data and error taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
        @(posedge SYS_CLK);
        PENABLE <= 1;
        @(posedge SYS_CLK);
        while (PREADY !== 1'b1) @(posedge SYS_CLK);
        q = PRDATA;
        e = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
        #1;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0);
        cmp("prdata", x, q);
    endtask
    // one instruction check and its answer
    task chk(input logic [2:0] c, input logic [3:0] m, input logic [1:0] mf, input logic [7:0] p,
            input logic [9:0] f, input logic [16:0] lb, input logic [1:0] cpl, input logic [3:0] x);
        @(posedge SYS_CLK);
        CHK_VALID <= 1;
        {CHK_CLASS, CHK_MODE, CHK_MODFIELD, CHK_PREFIX, flg, CHK_LAST_BYTE, CHK_CPL} <=
            {c, m, mf, p, f, lb, cpl};
        @(posedge SYS_CLK);
        CHK_VALID <= 0;
        #1;
        cmp("fault_valid", 1, FAULT_VALID);
        cmp("fault_code", x, FAULT_CODE);
    endtask
    // one delivery and its answer
    task dlv(input logic [7:0] v, input logic n, input logic t, input logic [7:0] ov,
            input logic df);
        @(posedge SYS_CLK);
        {DLV_VALID, DLV_VECTOR, DLV_IS_NMI} <= {1'b1, v, n};
        @(posedge SYS_CLK);
        DLV_VALID <= 0;
        #1;
        cmp("dlv_done", 1, DLV_DONE);
        cmp("dlv_taken", t, DLV_TAKEN);
        cmp("dlv_df", df, DLV_DF);
        if (t) cmp("dlv_vector", ov, DLV_OUT_VECTOR);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----
    // clock, timeout, main sequence
    // ----
    initial forever #2.5 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge SYS_CLK);
        SYS_RST <= 0;
        rd(`SFC_ADDR_TLIMIT, 32'h3ff);
        rd(`SFC_ADDR_STATUS, 32'h0);
        rd(`SFC_ADDR_CTRL, 32'h0);
        apb(0, 12'h014, 0);
        cmp("slverr", 1, e);
        chk(N, PM, 2'h3, 8'h00, 10'h200, 0, 0, OK);
        chk(N, PM, 2'h3, 8'hf0, 10'h200, 0, 0, BAD);
        chk(N, PM, 2'h3, 8'h00, 10'h000, 0, 0, BAD);
        chk(M, PM, 2'h0, 8'h00, 10'h200, 0, 0, BAD);
        chk(N, RM, 2'h3, 8'h00, 10'h300, 0, 0, FPE);
        chk(N, PM, 2'h3, 8'h00, 10'h280, 0, 0, STK);
        chk(N, LM, 2'h3, 8'h00, 10'h240, 0, 0, STK);
        chk(N, PM, 2'h3, 8'h00, 10'h220, 0, 0, PRO);
        chk(R, PM, 2'h3, 8'h00, 10'h208, 0, 0, PRO);
        chk(N, PM, 2'h3, 8'h00, 10'h208, 0, 0, OK);
        chk(M, PM, 2'h3, 8'h00, 10'h204, 0, 0, PRO);
        chk(N, LM, 2'h3, 8'h00, 10'h210, 0, 0, PRO);
        chk(N, RM, 2'h3, 8'h00, 10'h200, 17'h0ffff, 0, OK);
        chk(N, RM, 2'h3, 8'h00, 10'h200, 17'h10000, 0, PRO);
        chk(N, PM, 2'h3, 8'h00, 10'h203, 0, 3, ALN);
        chk(N, RM, 2'h3, 8'h00, 10'h203, 0, 3, OK);
        chk(N, PM, 2'h3, 8'h00, 10'h203, 0, 2, OK);
        @(posedge SYS_CLK) CHK_MEMREF <= 0;
        chk(N, PM, 2'h3, 8'h00, 10'h2a3, 0, 3, OK);
        chk(N, PM, 2'h3, 8'hf0, 10'h2a3, 0, 3, BAD);
        @(posedge SYS_CLK) CHK_MEMREF <= 1;
        apb(1, `SFC_ADDR_CTRL, 32'h4);
        chk(N, RM, 2'h3, 8'h00, 10'h200, 0, 0, BAD);
        apb(1, `SFC_ADDR_CTRL, 32'h0);
        rd(`SFC_ADDR_STATUS, 32'h1f);
        cmp("irq", 0, IRQ);
        apb(1, `SFC_ADDR_ENABLE, 32'h10);
        cmp("irq", 1, IRQ);
        apb(1, `SFC_ADDR_CLEAR, 32'h10);
        cmp("irq", 0, IRQ);
        rd(`SFC_ADDR_STATUS, 32'h0f);
        apb(1, `SFC_ADDR_CLEAR, 32'h0f);
        @(posedge SYS_CLK) {CLK_EN, CHK_VALID, CHK_PREFIX} <= {1'b0, 1'b1, 8'hf0};
        @(posedge SYS_CLK) CHK_VALID <= 0;
        #1;
        cmp("frozen_valid", 0, FAULT_VALID);
        @(posedge SYS_CLK) CLK_EN <= 1;
        dlv(8'h05, 0, 1, 8'h05, 0);
        apb(1, `SFC_ADDR_TLIMIT, 32'h4f);
        dlv(8'h09, 0, 1, 8'h09, 0);
        dlv(8'h0a, 0, 1, 8'h08, 1);
        dlv(8'h02, 1, 1, 8'h02, 0);
        dlv(8'h02, 1, 0, 8'h00, 0);
        @(posedge SYS_CLK) INTERRUPT_RETURN_DONE <= 1;
        @(posedge SYS_CLK) INTERRUPT_RETURN_DONE <= 0;
        dlv(8'h02, 1, 1, 8'h02, 0);
        apb(1, `SFC_ADDR_TLIMIT, 32'h3f);
        dlv(8'h0a, 0, 0, 8'h00, 0);
        cmp("shutdown", 1, SHUTDOWN);
        dlv(8'h01, 0, 0, 8'h00, 0);
        rd(`SFC_ADDR_STATUS, 32'he0);
        tally_and_finish;
    end
endmodule
